// ===== td_tamper_top.sv
// two-channel tamper detector with config/flag registers, irq, ram clear
//
// Function
// - two independent channels, each flag settable only while its enable is set
// - tamper is a normally-open switch closing or normally-closed switch opening
// - enable bit one arms the channel; zero disables detection
// - enabled channel sets its flag in the flag register on tamper
// - flag is read-only; cleared only by writing enable to zero
// - irq enable one drives the interrupt pin on that channel's tamper
// - in battery backup, interrupt also needs the alarm-in-backup enable
// - switch type bit: one normally-open, zero normally-closed
// - trigger level bit: one tamper drives pin high, zero low
// - during the external clear interval, a high-level tamper is not detected
// - normally-closed mode may sample at 1 Hz instead of continuous watching
// - a stopped oscillator forces continuous watching
// - ram clear with enable set zeros all user ram on tamper
// - after a clear, user ram stays locked until that enable is zeroed
`timescale 1ns/1ps
`default_nettype none
`include "td_cfg.svh"

module td_tamper_top
  import td_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `TD_SAMPLE_CYCLES,
  parameter int CLEAR_CYCLES  = `TD_CLEAR_CYCLES
)
(
  input  wire logic      clock_in,
  input  wire logic      rst_in,
  input  wire td_pkg::td_byte_t reg_addr_in,
  input  wire logic      reg_wr_in,
  input  wire td_pkg::td_byte_t reg_wdata_in,
  output td_pkg::td_byte_t      reg_rdata_out,
  input  wire logic      tamper_input_one_in,
  input  wire logic      tamper_input_two_in,
  input  wire logic      battery_backup_in,
  input  wire logic      alarm_in_backup_enable_in,
  input  wire logic      osc_running_in,
  output logic           irq_n_out,
  output logic           user_ram_clear_out,
  output logic           user_ram_locked_out,
  output logic           ext_ram_clear_out
);
  import td_pkg::*;

  td_byte_t              cfg_reg [`TD_NUM_CH];
  td_chan_t              flag;
  td_chan_t              flag_prev_reg;
  td_chan_t              lock_reg;
  td_chan_t              pins;
  td_chan_t              rise;
  logic [`TD_CNT_W-1:0]  tick_cnt_reg;
  logic                  tick_reg;
  logic [`TD_CNT_W-1:0]  clr_cnt_reg;
  td_clr_state_e         clr_state_reg;
  logic                  irq_next;
  logic                  ext_start;
  logic                  ram_start;
  td_byte_t              rdata_next;
  logic                  in_backup_meta_reg;
  logic                  in_backup_reg;
  logic                  osc_meta_reg;
  logic                  osc_reg;

  assign pins = {tamper_input_two_in, tamper_input_one_in};

  // status levels come from the supply/oscillator side, so synchronise them too
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      in_backup_meta_reg <= 1'b0;
      in_backup_reg      <= 1'b0;
      osc_meta_reg       <= 1'b0;
      osc_reg            <= 1'b0;
    end
    else
    begin
      in_backup_meta_reg <= battery_backup_in;
      in_backup_reg      <= in_backup_meta_reg;
      osc_meta_reg       <= osc_running_in;
      osc_reg            <= osc_meta_reg;
    end
  end

  // 1 Hz sampling strobe; counter wraps instead of using a slow clock
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg == `TD_CNT_W'(SAMPLE_CYCLES - 1))
    begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + `TD_CNT_W'(1);
      tick_reg     <= 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `TD_NUM_CH; i++)
    begin : g_ch
      always_ff @(posedge clock_in)
      begin
        if (rst_in)
          cfg_reg[i] <= `TD_CFG_RESET;
        else if (reg_wr_in && (reg_addr_in == (`TD_OFF_CH1 + 8'(i))))
          cfg_reg[i] <= reg_wdata_in;
      end

      td_channel u_chan (
        .clock_in                 (clock_in),
        .rst_in                   (rst_in),
        .tamper_pin_in            (pins[i]),
        .tamper_enable_in         (cfg_reg[i][`TD_BIT_ENABLE]),
        .switch_type_select_in    (cfg_reg[i][`TD_BIT_SW_TYPE]),
        .trigger_level_select_in  (cfg_reg[i][`TD_BIT_TRIG_LVL]),
        .input_sampling_select_in (cfg_reg[i][`TD_BIT_SAMPLING]),
        .sample_tick_in           (tick_reg),
        .osc_running_in           (osc_reg),
        .block_high_in            (clr_state_reg == TD_CLR_PULSE),
        .tamper_flag_out          (flag[i])
      );

      assign rise[i] = flag[i] && !flag_prev_reg[i];

      // lock holds until this channel's enable is written to zero
      always_ff @(posedge clock_in)
      begin
        if (rst_in)
          lock_reg[i] <= 1'b0;
        else if (!cfg_reg[i][`TD_BIT_ENABLE])
          lock_reg[i] <= 1'b0;
        else if (rise[i] && cfg_reg[i][`TD_BIT_RAM_CLR])
          lock_reg[i] <= 1'b1;
      end
    end
  endgenerate

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      flag_prev_reg <= '0;
    else
      flag_prev_reg <= flag;
  end

  assign ram_start = (rise[0] && cfg_reg[0][`TD_BIT_RAM_CLR]) || (rise[1] && cfg_reg[1][`TD_BIT_RAM_CLR]);
  assign ext_start = (rise[0] && cfg_reg[0][`TD_BIT_EXT_CLR]) || (rise[1] && cfg_reg[1][`TD_BIT_EXT_CLR]);

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      user_ram_clear_out  <= 1'b0;
      user_ram_locked_out <= 1'b0;
    end
    else
    begin
      user_ram_clear_out  <= ram_start;
      user_ram_locked_out <= |lock_reg;
    end
  end

  // external clear interval; a tamper during it does not restart the pulse
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      clr_state_reg     <= TD_CLR_IDLE;
      clr_cnt_reg       <= '0;
      ext_ram_clear_out <= 1'b0;
    end
    else
    begin
      case (clr_state_reg)
        TD_CLR_IDLE:
        begin
          if (ext_start)
          begin
            clr_state_reg     <= TD_CLR_PULSE;
            clr_cnt_reg       <= `TD_CNT_W'(CLEAR_CYCLES - 1);
            ext_ram_clear_out <= 1'b1;
          end
        end
        TD_CLR_PULSE:
        begin
          if (clr_cnt_reg == '0)
          begin
            clr_state_reg     <= TD_CLR_IDLE;
            ext_ram_clear_out <= 1'b0;
          end
          else
            clr_cnt_reg <= clr_cnt_reg - `TD_CNT_W'(1);
        end
        default:
          clr_state_reg <= TD_CLR_IDLE;
      endcase
    end
  end

  // level interrupt: stays low until the flag or its irq enable is cleared, or backup starts without the alarm enable
  assign irq_next = ((flag[0] && cfg_reg[0][`TD_BIT_IRQ_EN]) || (flag[1] && cfg_reg[1][`TD_BIT_IRQ_EN]))
                    && (!in_backup_reg || alarm_in_backup_enable_in);
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      irq_n_out <= 1'b1;
    else
      irq_n_out <= !irq_next;
  end

  // flag register is read-only: writes to it are dropped
  always_comb
  begin
    rdata_next = `TD_BYTE_ZERO;
    if (reg_addr_in == `TD_OFF_FLAGS)
      rdata_next = {6'h00, flag};
    else if (reg_addr_in == `TD_OFF_CH1)
      rdata_next = cfg_reg[0];
    else if (reg_addr_in == `TD_OFF_CH2)
      rdata_next = cfg_reg[1];
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      reg_rdata_out <= `TD_BYTE_ZERO;
    else
      reg_rdata_out <= rdata_next;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_FLAG_ONE_NEEDS_ENABLE: assert property ($rose(flag[0]) |-> $past(cfg_reg[0][`TD_BIT_ENABLE]))
    else $error("channel one flag rose while disabled");
  AST_FLAG_CLEAR_BY_ENABLE: assert property (reg_wr_in && reg_addr_in == `TD_OFF_CH2
                                             && !reg_wdata_in[`TD_BIT_ENABLE] |=> ##1 !flag[1])
    else $error("disable write did not clear channel two flag");
  AST_FLAG_WRITE_IGNORED: assert property (reg_wr_in && reg_addr_in == `TD_OFF_FLAGS && flag[0]
                                           && cfg_reg[0][`TD_BIT_ENABLE] |=> flag[0])
    else $error("write to flag register cleared a flag");
  AST_IRQ_ON_TAMPER: assert property (flag[0] && cfg_reg[0][`TD_BIT_IRQ_EN] && !in_backup_reg |=> !irq_n_out)
    else $error("interrupt not raised for enabled tamper");
  AST_IRQ_BACKUP_GATED: assert property (in_backup_reg && !alarm_in_backup_enable_in |=> irq_n_out)
    else $error("interrupt raised in backup without alarm enable");
  AST_IRQ_MASKED: assert property (!cfg_reg[0][`TD_BIT_IRQ_EN] && !cfg_reg[1][`TD_BIT_IRQ_EN] |=> irq_n_out)
    else $error("interrupt raised with both irq enables off");
  AST_RAM_CLEAR_PULSE: assert property ((rise[0] && cfg_reg[0][`TD_BIT_RAM_CLR] && cfg_reg[0][`TD_BIT_ENABLE])
                                        || (rise[1] && cfg_reg[1][`TD_BIT_RAM_CLR] && cfg_reg[1][`TD_BIT_ENABLE])
                                        |=> user_ram_clear_out ##1 user_ram_locked_out)
    else $error("ram clear or lock missing after tamper");
  AST_RAM_LOCK_RELEASE: assert property (!cfg_reg[0][`TD_BIT_ENABLE] && !cfg_reg[1][`TD_BIT_ENABLE]
                                         |=> ##1 !user_ram_locked_out)
    else $error("ram lock held after enables cleared");
  AST_RAM_LOCK_HOLD: assert property (lock_reg[0] && cfg_reg[0][`TD_BIT_ENABLE] |=> lock_reg[0])
    else $error("ram lock dropped while enabled");
  AST_EXT_CLR_START: assert property (ext_start && clr_state_reg == TD_CLR_IDLE |=> ext_ram_clear_out)
    else $error("external clear interval did not start");

  COV_TAMPER_IRQ: cover property ($fell(irq_n_out));
  COV_RAM_CLEAR: cover property (user_ram_clear_out);
  COV_REARM: cover property (flag[0] ##[1:4] !flag[0] ##[1:4] cfg_reg[0][`TD_BIT_ENABLE]);
  COV_BOTH_FLAGS: cover property (flag == 2'h3);

endmodule

`default_nettype wire

// ===== td_cfg.svh
// constants for the two-channel tamper detector: offsets, bit positions, timing
`ifndef TD_CFG_SVH
`define TD_CFG_SVH

`define TD_OFF_FLAGS     8'h0F
`define TD_OFF_CH1       8'h14
`define TD_OFF_CH2       8'h15

`define TD_BIT_ENABLE    7
`define TD_BIT_IRQ_EN    6
`define TD_BIT_SW_TYPE   5
`define TD_BIT_TRIG_LVL  4
`define TD_BIT_SAMPLING  3
`define TD_BIT_EXT_CLR   2
`define TD_BIT_RAM_CLR   1

`define TD_CFG_RESET     8'h00
`define TD_BYTE_ZERO     8'h00

`define TD_CLK_HZ        200000000
`define TD_SAMPLE_HZ     1
`define TD_CLEAR_MS      1000
`define TD_SAMPLE_CYCLES (`TD_CLK_HZ / `TD_SAMPLE_HZ)
`define TD_CLEAR_CYCLES  ((`TD_CLK_HZ / 1000) * `TD_CLEAR_MS)

`define TD_CNT_W         28
`define TD_NUM_CH        2

`endif

// ===== td_pkg.sv
// shared types for the two-channel tamper detector
package td_pkg;
  typedef logic [7:0] td_byte_t;
  typedef logic [1:0] td_chan_t;
  typedef enum logic {TD_CLR_IDLE, TD_CLR_PULSE} td_clr_state_e;
endpackage

// ===== td_channel.sv
// one tamper channel: input synchroniser, trigger evaluation, sticky flag
`timescale 1ns/1ps
`default_nettype none
`include "td_cfg.svh"

module td_channel
  import td_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic tamper_pin_in,
  input  wire logic tamper_enable_in,
  input  wire logic switch_type_select_in,
  input  wire logic trigger_level_select_in,
  input  wire logic input_sampling_select_in,
  input  wire logic sample_tick_in,
  input  wire logic osc_running_in,
  input  wire logic block_high_in,
  output logic      tamper_flag_out
);

  logic meta_reg;
  logic sync_reg;
  logic active;
  logic sampled_mode;
  logic look;

  // two flops before anything reads the pin
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= tamper_pin_in;
      sync_reg <= meta_reg;
    end
  end

  // the trigger level is the same test for both switch types; the type only decides sampling
  assign active       = (sync_reg == trigger_level_select_in);
  // sampling only for normally-closed, and only while the oscillator runs
  assign sampled_mode = !switch_type_select_in && input_sampling_select_in && osc_running_in;
  assign look         = sampled_mode ? sample_tick_in : 1'b1;
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      tamper_flag_out <= 1'b0;
    else if (!tamper_enable_in)
      tamper_flag_out <= 1'b0;
    else if (active && look && !(block_high_in && trigger_level_select_in))
      tamper_flag_out <= 1'b1;
    // otherwise hold, even if the pin goes quiet again
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_CH_NO_ENABLE_NO_FLAG: assert property (!tamper_enable_in |=> !tamper_flag_out)
    else $error("flag set or held with channel disabled");
  AST_CH_STICKY: assert property (tamper_flag_out && tamper_enable_in |=> tamper_flag_out)
    else $error("flag dropped while enabled");
  AST_CH_DETECT: assert property (tamper_enable_in && active && !sampled_mode && !block_high_in
                                  |=> tamper_flag_out)
    else $error("continuous tamper not flagged");
  AST_CH_SAMPLE_GAP: assert property (sampled_mode && !sample_tick_in && !tamper_flag_out
                                      |=> !tamper_flag_out)
    else $error("flag set between sample ticks");
  AST_CH_HIGH_BLOCKED: assert property (block_high_in && trigger_level_select_in && !tamper_flag_out
                                        |=> !tamper_flag_out)
    else $error("high tamper seen during clear interval");
  AST_CH_PIN_TO_FLAG: assert property (tamper_enable_in && !switch_type_select_in && !block_high_in
                                       && (tamper_pin_in == trigger_level_select_in)
                                       ##1 (tamper_pin_in == trigger_level_select_in) && tamper_enable_in
                                       && !block_high_in && !sampled_mode
                                       ##1 tamper_enable_in && !block_high_in && !sampled_mode
                                       |=> tamper_flag_out)
    else $error("stable tamper level not flagged after synchroniser");

endmodule

`default_nettype wire

// ===== td_switch_model.sv
// model of the two external tamper switches with their pull resistors
`timescale 1ns/1ps
`default_nettype none

module td_switch_model
(
  input  wire logic [1:0] switch_closed_in,
  input  wire logic [1:0] normally_open_in,
  input  wire logic [1:0] to_high_in,
  output logic      [1:0] pin_out
);
  logic [1:0] disturbed;

  // closing a normally-open or opening a normally-closed switch is the tamper
  assign disturbed = ~(switch_closed_in ^ normally_open_in);
  // the pin never floats: it sits at the trigger level or at its inverse
  assign pin_out = disturbed ~^ to_high_in;
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the two-channel tamper detector
`timescale 1ns/1ps
`default_nettype none
`include "td_cfg.svh"

module testbench;
  import td_pkg::*;
  localparam int SMP = 64;
  localparam int CLR = 48;
  typedef struct {logic [2:0] kind; td_byte_t exp;} td_note_s;
  logic        clock_in   = 1'b0;
  logic        rst_in     = 1'b1;
  td_byte_t    addr       = 8'h00;
  td_byte_t    wdata      = 8'h00;
  td_byte_t    rdata;
  logic        wr         = 1'b0;
  logic [1:0]  closed     = 2'b00;
  logic [1:0]  nopen      = 2'b11;
  logic [1:0]  hi         = 2'b00;
  logic [1:0]  pins;
  logic        bat        = 1'b0;
  logic        abe        = 1'b0;
  logic        osc        = 1'b1;
  logic        irq_n;
  logic        ram_clr;
  logic        locked;
  logic        ext_clr;
  logic        chk_req    = 1'b0;
  logic [31:0] lfsr       = 32'h0104;
  int          n_errors   = 0;
  int          n_compared = 0;
  td_note_s    notes[$];
  string       knames[5]  = '{"read data", "irq_n", "ram locked", "ext clear", "ram clear"};

  td_tamper_top #(.SAMPLE_CYCLES(SMP), .CLEAR_CYCLES(CLR)) u_td_tamper_top (
    .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .tamper_input_one_in(pins[0]), .tamper_input_two_in(pins[1]),
    .battery_backup_in(bat), .alarm_in_backup_enable_in(abe), .osc_running_in(osc),
    .irq_n_out(irq_n), .user_ram_clear_out(ram_clr), .user_ram_locked_out(locked), .ext_ram_clear_out(ext_clr));

  td_switch_model u_td_switch_model (
    .switch_closed_in(closed), .normally_open_in(nopen), .to_high_in(hi), .pin_out(pins));

  always #2.5 clock_in = ~clock_in;

  function automatic logic [31:0] td_lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic td_byte_t cfg(input logic en, irq, no, h, smp, ext, ram);
    td_byte_t v;
    v = `TD_CFG_RESET;
    v[`TD_BIT_ENABLE] = en;
    v[`TD_BIT_IRQ_EN] = irq;
    v[`TD_BIT_SW_TYPE] = no;
    v[`TD_BIT_TRIG_LVL] = h;
    v[`TD_BIT_SAMPLING] = smp;
    v[`TD_BIT_EXT_CLR] = ext;
    v[`TD_BIT_RAM_CLR] = ram;
    return v;
  endfunction

  function automatic td_byte_t sel(input logic [2:0] k);
    case (k)
      3'h0: return rdata;
      3'h1: return {7'h00, irq_n};
      3'h2: return {7'h00, locked};
      3'h3: return {7'h00, ext_clr};
      default: return {7'h00, ram_clr};
    endcase
  endfunction

  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input td_byte_t seen, input td_byte_t exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  task automatic reg_write(input td_byte_t a, input td_byte_t d);
    @(negedge clock_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(negedge clock_in);
    wr    <= 1'b0;
  endtask

  // queues the expectation; the watcher compares one cycle later
  task automatic expect_at(input logic [2:0] k, input td_byte_t a, input td_byte_t e);
    @(negedge clock_in);
    addr    <= a;
    notes.push_back('{k, e});
    chk_req <= 1'b1;
    @(negedge clock_in);
    chk_req <= 1'b0;
  endtask

  task automatic wait_for(input logic [2:0] k, input td_byte_t v, input int lim);
    int i;
    for (i = 0; i < lim && sel(k) !== v; i++)
      @(negedge clock_in);
    check(knames[k], sel(k), v);
    if (sel(k) !== v)
      print_verdict();
  endtask

  task automatic tamper(input int ch, input logic on);
    closed[ch] = nopen[ch] ? on : ~on;
  endtask

  task automatic mode_case(input int ch, input logic no, input logic h);
    td_byte_t a;
    td_byte_t f;
    a = (ch != 0) ? `TD_OFF_CH2 : `TD_OFF_CH1;
    f = (ch != 0) ? 8'h02 : 8'h01;
    nopen[ch] = no;
    hi[ch] = h;
    reg_write(a, cfg(0, 1, no, h, 0, 0, 0));
    tamper(ch, 1'b1);
    idle(6);
    expect_at(0, `TD_OFF_FLAGS, 8'h00);
    tamper(ch, 1'b0);
    idle(4);
    reg_write(a, cfg(1, 1, no, h, 0, 0, 0));
    idle(6);
    expect_at(0, `TD_OFF_FLAGS, 8'h00);
    tamper(ch, 1'b1);
    idle(6);
    expect_at(0, `TD_OFF_FLAGS, f);
    expect_at(1, `TD_OFF_FLAGS, 8'h00);
    tamper(ch, 1'b0);
    idle(6);
    expect_at(0, `TD_OFF_FLAGS, f);
    reg_write(a, cfg(0, 1, no, h, 0, 0, 0));
    idle(2);
    expect_at(0, `TD_OFF_FLAGS, 8'h00);
    expect_at(1, `TD_OFF_FLAGS, 8'h01);
  endtask

  always @(negedge clock_in)
  begin
    td_note_s n;
    if (chk_req)
    begin
      n = notes.pop_front();
      check(knames[n.kind], sel(n.kind), n.exp);
    end
  end

  initial
  begin
    idle(4);
    rst_in <= 1'b0;
    expect_at(0, `TD_OFF_CH1, `TD_CFG_RESET);
    expect_at(0, `TD_OFF_CH2, `TD_CFG_RESET);
    expect_at(1, `TD_OFF_FLAGS, 8'h01);
    expect_at(3, `TD_OFF_FLAGS, 8'h00);
    // random disarmed setups must store whole and never raise a flag
    repeat (4)
    begin
      lfsr = td_lfsr(lfsr);
      reg_write(`TD_OFF_CH2, lfsr[7:0] & 8'h7F);
      expect_at(0, `TD_OFF_CH2, lfsr[7:0] & 8'h7F);
    end
    reg_write(`TD_OFF_FLAGS, 8'hFF);
    reg_write(8'h30, 8'hFF);
    expect_at(0, `TD_OFF_FLAGS, 8'h00);
    expect_at(0, 8'h30, 8'h00);
    for (int m = 0; m < 8; m++)
      mode_case(m % 2, m[1], m[2]);
    hi[0] = 1'b0;
    tamper(0, 1'b0);
    idle(4);
    reg_write(`TD_OFF_CH1, cfg(1, 1, 1, 0, 0, 0, 0));
    bat = 1'b1;
    tamper(0, 1'b1);
    idle(6);
    expect_at(1, `TD_OFF_FLAGS, 8'h01);
    abe = 1'b1;
    idle(3);
    expect_at(1, `TD_OFF_FLAGS, 8'h00);
    bat = 1'b0;
    abe = 1'b0;
    reg_write(`TD_OFF_CH1, cfg(1, 0, 1, 0, 0, 0, 0));
    idle(2);
    expect_at(1, `TD_OFF_FLAGS, 8'h01);
    expect_at(0, `TD_OFF_FLAGS, 8'h01);
    reg_write(`TD_OFF_FLAGS, `TD_BYTE_ZERO);
    expect_at(0, `TD_OFF_FLAGS, 8'h01);
    tamper(0, 1'b0);
    reg_write(`TD_OFF_CH1, `TD_BYTE_ZERO);
    idle(4);
    reg_write(`TD_OFF_CH1, cfg(1, 0, 1, 0, 0, 0, 1));
    tamper(0, 1'b1);
    wait_for(4, 8'h01, 8);
    idle(2);
    expect_at(2, `TD_OFF_FLAGS, 8'h01);
    tamper(0, 1'b0);
    reg_write(`TD_OFF_CH1, `TD_BYTE_ZERO);
    idle(3);
    expect_at(2, `TD_OFF_FLAGS, 8'h00);
    // a high-level tamper on the other channel is blind during the clear interval
    reg_write(`TD_OFF_CH1, cfg(1, 0, 1, 0, 0, 1, 0));
    reg_write(`TD_OFF_CH2, cfg(1, 0, 1, 1, 0, 0, 0));
    tamper(0, 1'b1);
    wait_for(3, 8'h01, 8);
    tamper(1, 1'b1);
    idle(6);
    expect_at(0, `TD_OFF_FLAGS, 8'h01);
    wait_for(3, 8'h00, CLR);
    idle(6);
    expect_at(0, `TD_OFF_FLAGS, 8'h03);
    tamper(0, 1'b0);
    reg_write(`TD_OFF_CH1, `TD_BYTE_ZERO);
    reg_write(`TD_OFF_CH2, `TD_BYTE_ZERO);
    nopen[1] = 1'b0;
    tamper(1, 1'b0);
    osc = 1'b0;
    idle(6);
    reg_write(`TD_OFF_CH2, cfg(1, 1, 0, 1, 1, 0, 0));
    tamper(1, 1'b1);
    idle(6);
    expect_at(0, `TD_OFF_FLAGS, 8'h02);
    tamper(1, 1'b0);
    reg_write(`TD_OFF_CH2, `TD_BYTE_ZERO);
    osc = 1'b1;
    idle(6);
    reg_write(`TD_OFF_CH2, cfg(1, 1, 0, 1, 1, 0, 0));
    tamper(1, 1'b1);
    wait_for(1, 8'h00, SMP + 8);
    // a tick was just taken, so a short tamper well before the next one must be missed
    tamper(1, 1'b0);
    reg_write(`TD_OFF_CH2, `TD_BYTE_ZERO);
    reg_write(`TD_OFF_CH2, cfg(1, 1, 0, 1, 1, 0, 0));
    tamper(1, 1'b1);
    idle(8);
    tamper(1, 1'b0);
    idle(4);
    expect_at(0, `TD_OFF_FLAGS, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
